// ==== hw/clfc_cfg.svh ====
// named constants of the current limit fault controller
`ifndef CLFC_CFG_SVH
`define CLFC_CFG_SVH

// ****************************************
// clock and time figures
// ****************************************
`define CLFC_CLK_PERIOD_NS     10
`define CLFC_TSTART_DEFAULT_MS 100
`define CLFC_RETRY_MS          1000
`define CLFC_FT_OFF_US         580
`define CLFC_RAMP_US           360
`define CLFC_FT_RESP_NS        1500
`define CLFC_BLANK_US          1000
`define CLFC_DEB_US            100

// least times round up, longest times round down
`define CLFC_CYC_UP(ns) (((ns) + `CLFC_CLK_PERIOD_NS - 1) / `CLFC_CLK_PERIOD_NS)
`define CLFC_CYC_DN(ns) ((ns) / `CLFC_CLK_PERIOD_NS)

// ****************************************
// strap codes, widths, reset values
// ****************************************
`define CLFC_STRAP_OPEN  2'h0
`define CLFC_STRAP_GND   2'h1
`define CLFC_STRAP_RES   2'h2
`define CLFC_CNT_W       32
`define CLFC_SCALE_W     8
`define CLFC_SCALE_FULL  8'hff
`define CLFC_SCALE_ZERO  8'h00
`define CLFC_SCALE_STEPS 256
`define CLFC_CNT_ZERO    32'h0
`define CLFC_CNT_ONE     32'h1

`endif

// ==== hw/clfc_pkg.sv ====
// types shared by the current limit fault controller
package clfc_pkg;

   // ****************************************
   // sequencer states and response modes
   // ****************************************
   typedef enum logic [3:0] {
      CLFC_ST_OFF      = 4'b0000,
      CLFC_ST_DEBOUNCE = 4'b0001,
      CLFC_ST_STARTUP  = 4'b0010,
      CLFC_ST_NORMAL   = 4'b0011,
      CLFC_ST_TRIP_OFF = 4'b0100,
      CLFC_ST_RAMP     = 4'b0101,
      CLFC_ST_RETRY    = 4'b0110,
      CLFC_ST_LATCHED  = 4'b0111,
      CLFC_ST_THERMAL  = 4'b1000
   } clfc_st_type;

   typedef enum logic [1:0] {
      CLFC_MODE_AUTORETRY  = 2'b00,
      CLFC_MODE_CONTINUOUS = 2'b01,
      CLFC_MODE_LATCHOFF   = 2'b10
   } clfc_mode_type;

   typedef struct packed {
      clfc_st_type   st;
      clfc_mode_type mode;
      logic [31:0]   cnt;
      logic [31:0]   blank;
      logic [31:0]   step;
      logic [7:0]    scale;
      logic          fault;
      logic          in_sw;
      logic          out_sw;
      logic          regulate;
      logic          flag_oe;
      logic          supply_window_fault_oe;
   } clfc_state_type;

   // strap decode: open autoretry, ground continuous, resistor latch-off
   function automatic clfc_mode_type clfc_decode_mode(input logic [1:0] s);
      if (s == 2'h1) begin
         return CLFC_MODE_CONTINUOUS;
      end else if (s == 2'h2) begin
         return CLFC_MODE_LATCHOFF;
      end else begin
         return CLFC_MODE_AUTORETRY;
      end
   endfunction

   // true on the last cycle of a count of lim cycles
   function automatic logic clfc_done(input logic [31:0] cnt,
                                      input logic [31:0] lim);
      return (cnt + 32'h1) >= lim;
   endfunction

endpackage

// ==== hw/clfc_pin_sync.sv ====
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module clfc_pin_sync
   import clfc_pkg::*;
#(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         core_clk_in,
   input  wire logic         rst_in,
   // pins and filtered levels
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] level_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } clfc_sync_type;

   clfc_sync_type r_q;
   clfc_sync_type r_d;

   // s1 feeds only s2; a bit changes once s2 and s3 agree
   always_comb begin
      r_d     = r_q;
      r_d.s1  = pin_in;
      r_d.s2  = r_q.s1;
      r_d.s3  = r_q.s2;
      r_d.lvl = (~(r_q.s2 ^ r_q.s3) & r_q.s3) |
                ((r_q.s2 ^ r_q.s3) & r_q.lvl);
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign level_out = r_q.lvl;

endmodule

// ==== hw/clfc_fault_ctrl.sv ====
// current limit fault response sequencer of a protected power switch
`timescale 1ns/10ps
`include "clfc_cfg.svh"
module clfc_fault_ctrl
   import clfc_pkg::*;
#(
   parameter int unsigned TSTART_DEF_CYC =
      `CLFC_CYC_UP(`CLFC_TSTART_DEFAULT_MS * 1000000),
   parameter int unsigned RETRY_CYC  = `CLFC_CYC_UP(`CLFC_RETRY_MS * 1000000),
   parameter int unsigned FT_OFF_CYC = `CLFC_CYC_UP(`CLFC_FT_OFF_US * 1000),
   parameter int unsigned RAMP_CYC   = `CLFC_CYC_DN(`CLFC_RAMP_US * 1000),
   parameter int unsigned BLANK_CYC  = `CLFC_CYC_UP(`CLFC_BLANK_US * 1000),
   parameter int unsigned DEB_CYC    = `CLFC_CYC_UP(`CLFC_DEB_US * 1000)
) (
   // clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        rst_in,
   // pins from the system controller and board
   input  wire logic        enable_in,
   input  wire logic        supply_present_in,
   input  wire logic [1:0]  limit_response_select_in,
   // synchronous comparator outcomes
   input  wire logic        at_limit_in,
   input  wire logic        fast_trip_in,
   input  wire logic        output_at_target_in,
   input  wire logic        thermal_shutdown_in,
   input  wire logic        reverse_current_in,
   input  wire logic        limit_set_low_in,
   input  wire logic        supply_window_bad_in,
   input  wire logic        startup_cap_open_in,
   input  wire logic [31:0] startup_window_cycles_in,
   // switch drives
   output logic             input_switch_on_out,
   output logic             output_switch_on_out,
   output logic             limit_regulate_out,
   output logic [7:0]       limit_scale_out,
   // open-drain fault outputs, enable high pulls the pin low
   output logic             fault_flag_oe_out,
   output logic             supply_window_fault_oe_out
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   localparam int unsigned RAMP_STEP_CYC =
      (RAMP_CYC / `CLFC_SCALE_STEPS) > 0 ? RAMP_CYC / `CLFC_SCALE_STEPS : 1;
   localparam int FT_RESP_CYC = `CLFC_CYC_DN(`CLFC_FT_RESP_NS);

   logic [3:0]     pins_s;
   logic           en_s;
   logic [1:0]     strap_s;
   clfc_state_type r_q;
   clfc_state_type r_d;
   logic [31:0]    win;
   logic           running;

   clfc_pin_sync #(.W(4)) u_sync (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .pin_in      ({limit_response_select_in, supply_present_in, enable_in}),
      .level_out   (pins_s)
   );

   // enable toggle or supply loss both restart the sequence
   assign en_s    = pins_s[0] & pins_s[1];
   assign strap_s = pins_s[3:2];
   assign win     = startup_cap_open_in ? 32'(TSTART_DEF_CYC)
                                        : startup_window_cycles_in;
   assign running = (r_q.st == CLFC_ST_STARTUP) || (r_q.st == CLFC_ST_NORMAL) ||
                    (r_q.st == CLFC_ST_RAMP);

   // ****************************************
   // sequencer
   // ****************************************
   always_comb begin
      r_d          = r_q;
      r_d.cnt      = r_q.cnt + `CLFC_CNT_ONE;
      r_d.regulate = r_q.out_sw & at_limit_in;
      r_d.scale    = `CLFC_SCALE_FULL;
      if (!en_s) begin
         r_d       = '0;
         r_d.st    = CLFC_ST_OFF;
         r_d.mode  = r_q.mode;
      end else if (thermal_shutdown_in && running) begin
         r_d.out_sw   = 1'b0;
         r_d.regulate = 1'b0;
         r_d.cnt      = `CLFC_CNT_ZERO;
         r_d.blank    = `CLFC_CNT_ZERO;
         r_d.st       = (r_q.mode == CLFC_MODE_LATCHOFF) ? CLFC_ST_LATCHED
                                                         : CLFC_ST_THERMAL;
         r_d.fault    = (r_q.mode == CLFC_MODE_LATCHOFF) | r_q.fault;
      end else if (fast_trip_in && running) begin
         r_d.out_sw   = 1'b0;
         r_d.regulate = 1'b0;
         r_d.cnt      = `CLFC_CNT_ZERO;
         r_d.st       = CLFC_ST_TRIP_OFF;
      end else begin
         case (r_q.st)
            CLFC_ST_OFF: begin
               r_d.cnt  = `CLFC_CNT_ZERO;
               r_d.mode = clfc_decode_mode(strap_s);
               r_d.st   = CLFC_ST_DEBOUNCE;
            end
            CLFC_ST_DEBOUNCE: begin
               if (clfc_done(r_q.cnt, 32'(DEB_CYC))) begin
                  r_d.cnt    = `CLFC_CNT_ZERO;
                  r_d.in_sw  = 1'b1;
                  r_d.out_sw = 1'b1;
                  r_d.st     = CLFC_ST_STARTUP;
               end
            end
            CLFC_ST_STARTUP: begin
               // charging at limit current, a short is just an overload
               if (output_at_target_in) begin
                  r_d.cnt   = `CLFC_CNT_ZERO;
                  r_d.fault = 1'b0;
                  r_d.st    = CLFC_ST_NORMAL;
               end else if (clfc_done(r_q.cnt, win)) begin
                  r_d.cnt   = `CLFC_CNT_ZERO;
                  r_d.fault = 1'b1;
                  case (r_q.mode)
                     CLFC_MODE_CONTINUOUS: begin
                        r_d.st = CLFC_ST_NORMAL;
                     end
                     CLFC_MODE_LATCHOFF: begin
                        r_d.out_sw   = 1'b0;
                        r_d.regulate = 1'b0;
                        r_d.st       = CLFC_ST_LATCHED;
                     end
                     default: begin
                        r_d.out_sw   = 1'b0;
                        r_d.regulate = 1'b0;
                        r_d.st       = CLFC_ST_RETRY;
                     end
                  endcase
               end
            end
            CLFC_ST_NORMAL, CLFC_ST_RAMP: begin
               if (r_q.st == CLFC_ST_RAMP) begin
                  r_d.scale = r_q.scale;
                  r_d.step  = r_q.step + `CLFC_CNT_ONE;
                  if (clfc_done(r_q.step, 32'(RAMP_STEP_CYC))) begin
                     r_d.step  = `CLFC_CNT_ZERO;
                     r_d.scale = (r_q.scale == `CLFC_SCALE_FULL) ?
                                 r_q.scale : r_q.scale + 8'h01;
                  end
                  if (clfc_done(r_q.cnt, 32'(RAMP_CYC))) begin
                     r_d.scale = `CLFC_SCALE_FULL;
                     r_d.st    = CLFC_ST_NORMAL;
                  end
               end
               if (output_at_target_in) begin
                  r_d.fault = 1'b0;
               end
               if (!at_limit_in) begin
                  r_d.blank = `CLFC_CNT_ZERO;
               end else if (clfc_done(r_q.blank, 32'(BLANK_CYC))) begin
                  r_d.blank = `CLFC_CNT_ZERO;
                  r_d.cnt   = `CLFC_CNT_ZERO;
                  r_d.fault = 1'b1;
                  if (r_q.mode == CLFC_MODE_LATCHOFF) begin
                     r_d.out_sw   = 1'b0;
                     r_d.regulate = 1'b0;
                     r_d.st       = CLFC_ST_LATCHED;
                  end else if (r_q.mode == CLFC_MODE_AUTORETRY) begin
                     r_d.out_sw   = 1'b0;
                     r_d.regulate = 1'b0;
                     r_d.st       = CLFC_ST_RETRY;
                  end
               end else begin
                  r_d.blank = r_q.blank + `CLFC_CNT_ONE;
               end
            end
            CLFC_ST_TRIP_OFF: begin
               if (clfc_done(r_q.cnt, 32'(FT_OFF_CYC))) begin
                  r_d.cnt    = `CLFC_CNT_ZERO;
                  r_d.step   = `CLFC_CNT_ZERO;
                  r_d.scale  = `CLFC_SCALE_ZERO;
                  r_d.out_sw = 1'b1;
                  r_d.st     = CLFC_ST_RAMP;
               end
            end
            CLFC_ST_RETRY: begin
               if (clfc_done(r_q.cnt, 32'(RETRY_CYC))) begin
                  r_d.cnt    = `CLFC_CNT_ZERO;
                  r_d.out_sw = 1'b1;
                  r_d.st     = CLFC_ST_STARTUP;
               end
            end
            CLFC_ST_THERMAL: begin
               r_d.cnt = `CLFC_CNT_ZERO;
               if (!thermal_shutdown_in) begin
                  r_d.out_sw = 1'b1;
                  r_d.st     = CLFC_ST_STARTUP;
               end
            end
            CLFC_ST_LATCHED: begin
               r_d.cnt = `CLFC_CNT_ZERO;
            end
            default: begin
               r_d.st = CLFC_ST_OFF;
            end
         endcase
      end
      r_d.flag_oe = en_s & (r_d.fault | thermal_shutdown_in |
                    reverse_current_in | limit_set_low_in);
      r_d.supply_window_fault_oe = en_s & ~supply_window_bad_in;
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         r_q       <= '0;
         r_q.st    <= CLFC_ST_OFF;
         r_q.scale <= `CLFC_SCALE_FULL;
      end else begin
         r_q <= r_d;
      end
   end

   assign input_switch_on_out        = r_q.in_sw;
   assign output_switch_on_out       = r_q.out_sw;
   assign limit_regulate_out         = r_q.regulate;
   assign limit_scale_out            = r_q.scale;
   assign fault_flag_oe_out          = r_q.flag_oe;
   assign supply_window_fault_oe_out = r_q.supply_window_fault_oe;

   // ****************************************
   // checks
   // ****************************************
   enable_off_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !en_s |=> !r_q.in_sw && !r_q.out_sw && r_q.cnt == 32'h0)
      else $error("switches not off while disabled");

   fast_trip_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      en_s && running && fast_trip_in |-> ##[1:FT_RESP_CYC]
      !r_q.out_sw && r_q.in_sw)
      else $error("fast trip did not open the output switch");

   trip_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      r_q.st == CLFC_ST_RAMP && $past(r_q.st) == CLFC_ST_TRIP_OFF |->
      $past(r_q.cnt) == 32'(FT_OFF_CYC - 1) && r_q.out_sw && r_q.scale == 8'h00)
      else $error("trip off time wrong");

   latch_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      r_q.st == CLFC_ST_LATCHED && en_s |=>
      r_q.st == CLFC_ST_LATCHED && !r_q.out_sw && r_q.flag_oe)
      else $error("latch released while enabled");

   blank_clear_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      en_s && r_q.st == CLFC_ST_NORMAL && !at_limit_in && !fast_trip_in &&
      !thermal_shutdown_in |=> r_q.blank == 32'h0)
      else $error("blanking timer not cleared");

   retry_off_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      r_q.st == CLFC_ST_RETRY |-> !r_q.out_sw && r_q.in_sw && r_q.fault)
      else $error("output switch on during retry delay");

   cont_on_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      en_s && r_q.st == CLFC_ST_NORMAL && r_q.mode == CLFC_MODE_CONTINUOUS &&
      at_limit_in && !fast_trip_in && !thermal_shutdown_in |=> r_q.out_sw)
      else $error("continuous mode stopped conducting");

   regulate_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      en_s && r_q.st == CLFC_ST_NORMAL && at_limit_in && !fast_trip_in &&
      !thermal_shutdown_in |=> limit_regulate_out == output_switch_on_out)
      else $error("regulation not applied at limit");

   flag_src_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      en_s && (reverse_current_in || limit_set_low_in) |=> fault_flag_oe_out)
      else $error("fault flag missing");

   resp_time_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      en_s && running && fast_trip_in |=> !output_switch_on_out)
      else $error("fast trip missed the one cycle response");

endmodule

// ==== verif/clfc_sys_ctrl.sv ====
// system controller model: enable, supply and strap pins, flag readback
`timescale 1ns/10ps
module clfc_sys_ctrl (
   // clock and flag pin enable
   input  wire logic       core_clk_in,
   input  wire logic       fault_flag_oe_in,
   // pins into the block, flag pin level
   output logic            enable_out,
   output logic            supply_present_out,
   output logic [1:0]      limit_response_select_out,
   output logic            fault_flag_n_out
);
   // open-drain flag pin with board pull-up
   assign fault_flag_n_out = fault_flag_oe_in ? 1'b0 : 1'b1;
   initial begin
      enable_out = 1'b0;
      supply_present_out = 1'b1;
      limit_response_select_out = 2'h0;
   end
   task automatic pins(input logic en, input logic sp, input int n);
      @(negedge core_clk_in);
      enable_out = en;
      supply_present_out = sp;
      repeat (n) @(negedge core_clk_in);
   endtask
   // strap moves only while disabled
   task automatic power_up(input logic [1:0] strap);
      pins(1'b0, 1'b1, 6);
      limit_response_select_out = strap;
      pins(1'b1, 1'b1, 0);
   endtask
   task automatic toggle_enable();
      pins(1'b0, 1'b1, 6);
      pins(1'b1, 1'b1, 0);
   endtask
   task automatic cycle_supply();
      pins(1'b1, 1'b0, 6);
      pins(1'b1, 1'b1, 0);
   endtask
   task automatic shut_down();
      pins(1'b0, 1'b1, 0);
   endtask
endmodule

// ==== verif/clfc_fault_ctrl_tb_top.sv ====
// self-checking bench of the current limit fault controller
`timescale 1ns/10ps
module clfc_fault_ctrl_tb_top;
   // ****************************************
   // signals
   // ****************************************
   logic        core_clk_in;
   logic        rst_in;
   logic        enable;
   logic        supply_present;
   logic [1:0]  strap;
   logic        at_limit;
   logic        fast_trip;
   logic        tgt;
   logic        thermal;
   logic        reverse;
   logic        set_low;
   logic        sw_bad;
   logic        cap_open;
   logic [31:0] win;
   logic        in_sw;
   logic        out_sw;
   logic        regulate;
   logic [7:0]  scale;
   logic        flag_oe;
   logic        supply_window_fault_oe;
   logic        flag_n;
   logic [10:0] note_q[$];
   logic [10:0] nt;
   logic [7:0]  seen;
   logic [7:0]  seed;
   int          bad_count;
   int          tests_run;
   int          i;
   string       nm[7] = '{"out_sw", "in_sw", "flag", "supply_window_fault", "scale",
                          "regulate", "scale_mid"};

   // ****************************************
   // clock, partner and block
   // ****************************************
   initial begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end

   clfc_sys_ctrl ctrl_u (
      .core_clk_in               (core_clk_in),
      .fault_flag_oe_in          (flag_oe),
      .enable_out                (enable),
      .supply_present_out        (supply_present),
      .limit_response_select_out (strap),
      .fault_flag_n_out          (flag_n)
   );

   // short counts: window 200, retry 100, trip off 50, ramp 512
   clfc_fault_ctrl #(.TSTART_DEF_CYC(200), .RETRY_CYC(100),
      .FT_OFF_CYC(50), .RAMP_CYC(512), .BLANK_CYC(20), .DEB_CYC(10)) dut_u (
      .core_clk_in                (core_clk_in),
      .rst_in                     (rst_in),
      .enable_in                  (enable),
      .supply_present_in          (supply_present),
      .limit_response_select_in   (strap),
      .at_limit_in                (at_limit),
      .fast_trip_in               (fast_trip),
      .output_at_target_in        (tgt),
      .thermal_shutdown_in        (thermal),
      .reverse_current_in         (reverse),
      .limit_set_low_in           (set_low),
      .supply_window_bad_in       (sw_bad),
      .startup_cap_open_in        (cap_open),
      .startup_window_cycles_in   (win),
      .input_switch_on_out        (in_sw),
      .output_switch_on_out       (out_sw),
      .limit_regulate_out         (regulate),
      .limit_scale_out            (scale),
      .fault_flag_oe_out          (flag_oe),
      .supply_window_fault_oe_out (supply_window_fault_oe)
   );

   // ****************************************
   // tasks
   // ****************************************
   task automatic check(input logic [2:0] k, input logic [7:0] s,
                        input logic [7:0] e);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", nm[k], e, s);
      end
   endtask
   task automatic note(input logic [2:0] k, input logic [7:0] v);
      note_q.push_back({k, v});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk_in);
   endtask
   task automatic wait_out(input logic v, input int n);
      int j;
      for (j = 0; j < n && out_sw !== v; j++) @(negedge core_clk_in);
      if (j == n) begin
         bad_count++;
         $display("unexpected out_sw wait: expected %b seen %b", v, out_sw);
      end
   endtask
   task automatic start(input logic [1:0] s, input logic t);
      tgt = t;
      ctrl_u.power_up(s);
      wait_out(1'b1, 40);
      note(3'h1, 8'h01);
   endtask
   task automatic final_report();
      if (bad_count == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // ****************************************
   // result watcher: levels standing when the note was made
   // ****************************************
   always @(negedge core_clk_in) begin
      #1;
      while (note_q.size() > 0) begin
         nt = note_q.pop_front();
         case (nt[10:8])
            3'h0: seen = {7'h0, out_sw};
            3'h1: seen = {7'h0, in_sw};
            3'h2: seen = {7'h0, ~flag_n};
            3'h3: seen = {7'h0, supply_window_fault_oe};
            3'h4: seen = scale;
            3'h5: seen = {7'h0, regulate};
            default: seen = {7'h0, (scale > 8'h40) && (scale < 8'hc0)};
         endcase
         check(nt[10:8], seen, nt[7:0]);
      end
   end

   initial begin
      repeat (20000) @(posedge core_clk_in);
      bad_count++;
      final_report();
   end

   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      {at_limit, fast_trip, tgt, thermal} = 4'h0;
      {reverse, set_low, sw_bad, cap_open} = 4'h0;
      {bad_count, tests_run} = 0;
      win = 32'h1e;
      seed = 8'h13;
      rst_in = 1'b1;
      cyc(16);
      rst_in = 1'b0;
      note(3'h0, 8'h00);
      note(3'h2, 8'h00);
      note(3'h4, 8'hff);
      // continuous startup miss keeps charging
      start(2'h1, 1'b0);
      cyc(24);
      note(3'h2, 8'h00);
      cyc(12);
      note(3'h2, 8'h01);
      note(3'h0, 8'h01);
      tgt = 1'b1;
      cyc(4);
      note(3'h2, 8'h00);
      // short random limit bursts never flag
      for (i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         at_limit = 1'b1;
         cyc(int'(seed % 8'd18) + 1);
         at_limit = 1'b0;
         cyc(int'(seed[2:0]) + 2);
         note(3'h2, 8'h00);
      end
      at_limit = 1'b1;
      tgt = 1'b0;
      cyc(3);
      note(3'h5, 8'h01);
      cyc(22);
      note(3'h2, 8'h01);
      note(3'h0, 8'h01);
      at_limit = 1'b0;
      tgt = 1'b1;
      cyc(4);
      note(3'h2, 8'h00);
      // fast trip, off time and ramp
      fast_trip = 1'b1;
      cyc(1);
      fast_trip = 1'b0;
      note(3'h0, 8'h00);
      note(3'h1, 8'h01);
      cyc(44);
      note(3'h0, 8'h00);
      wait_out(1'b1, 12);
      note(3'h4, 8'h00);
      cyc(256);
      note(3'h6, 8'h01);
      cyc(270);
      note(3'h4, 8'hff);
      // thermal shutdown, resume when cool
      thermal = 1'b1;
      cyc(3);
      note(3'h0, 8'h00);
      note(3'h1, 8'h01);
      note(3'h2, 8'h01);
      thermal = 1'b0;
      wait_out(1'b1, 40);
      cyc(5);
      note(3'h2, 8'h00);
      // flag-only sources and supply window
      for (i = 0; i < 2; i++) begin
         reverse = (i == 0);
         set_low = (i != 0);
         cyc(3);
         note(3'h2, 8'h01);
         note(3'h0, 8'h01);
         reverse = 1'b0;
         set_low = 1'b0;
         cyc(3);
         note(3'h2, 8'h00);
      end
      note(3'h3, 8'h01);
      sw_bad = 1'b1;
      cyc(4);
      note(3'h3, 8'h00);
      sw_bad = 1'b0;
      // autoretry startup miss and retry cycles
      start(2'h0, 1'b0);
      cyc(36);
      note(3'h0, 8'h00);
      note(3'h1, 8'h01);
      note(3'h2, 8'h01);
      cyc(60);
      note(3'h0, 8'h00);
      wait_out(1'b1, 60);
      note(3'h2, 8'h01);
      tgt = 1'b1;
      cyc(4);
      note(3'h2, 8'h00);
      note(3'h0, 8'h01);
      // code 3 acts as autoretry: run overrun then retry
      start(2'h3, 1'b1);
      cyc(5);
      at_limit = 1'b1;
      cyc(24);
      note(3'h0, 8'h00);
      note(3'h1, 8'h01);
      note(3'h2, 8'h01);
      at_limit = 1'b0;
      cyc(50);
      note(3'h0, 8'h00);
      wait_out(1'b1, 60);
      // latch-off startup miss, released by enable
      start(2'h2, 1'b0);
      cyc(36);
      note(3'h0, 8'h00);
      note(3'h2, 8'h01);
      cyc(200);
      note(3'h0, 8'h00);
      note(3'h1, 8'h01);
      tgt = 1'b1;
      ctrl_u.toggle_enable();
      wait_out(1'b1, 40);
      cyc(5);
      note(3'h2, 8'h00);
      // latch-off run overrun, released by supply cycle
      at_limit = 1'b1;
      tgt = 1'b0;
      cyc(24);
      note(3'h0, 8'h00);
      note(3'h1, 8'h01);
      note(3'h2, 8'h01);
      at_limit = 1'b0;
      tgt = 1'b1;
      cyc(150);
      note(3'h0, 8'h00);
      ctrl_u.cycle_supply();
      wait_out(1'b1, 40);
      // unconnected window capacitor uses preset window
      cap_open = 1'b1;
      // programmed window well below the preset must be ignored
      seed = lfsr(seed);
      win = 32'(seed[5:0]) + 32'h10;
      start(2'h1, 1'b0);
      cyc(150);
      note(3'h2, 8'h00);
      cyc(60);
      note(3'h2, 8'h01);
      // disable clears everything but the response mode
      ctrl_u.shut_down();
      cyc(6);
      note(3'h0, 8'h00);
      note(3'h1, 8'h00);
      note(3'h2, 8'h00);
      note(3'h3, 8'h00);
      cyc(2);
      final_report();
   end
endmodule
